/* rtl/rxd_top.sv */
// Receive deserializer register block with APB slave and interrupt.
// Assumes an APB master on pclk and both channel inputs on pclk.
module rxd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rxd_pkg::rxd_bits_t rx_chan_a,
  input wire rxd_pkg::rxd_bits_t rx_chan_b,
  output logic irq
);
  localparam int NCH = 2;
  localparam int BW = rxd_pkg::BYTE_W;
  localparam int IW = rxd_pkg::IDX_W;

  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic [BW-1:0] control_reg;
  logic [BW-1:0] serdes_reg;
  logic [BW-1:0] irq_en_reg;
  logic [BW-1:0] data_reg [NCH];
  logic [BW-1:0] mask_reg [NCH];
  logic [NCH-1:0] unread_reg;
  logic [BW-1:0] flags;
  logic [BW-1:0] flag_set;
  logic [BW-1:0] flag_clr;
  logic [BW-1:0] rd_byte;
  logic [BW-1:0] stat_view;
  rxd_pkg::rxd_bits_t chan_in [NCH];
  rxd_pkg::rxd_load_t ev [NCH];
  logic access;
  logic done;
  logic wr;
  logic rd;
  logic rx_mode;
  logic [IW-1:0] idx;

  function automatic logic [IW-1:0] byte_idx(input int ch);
    return (ch == 0) ? rxd_pkg::IDX_BYTE_A : rxd_pkg::IDX_BYTE_B;
  endfunction

  function automatic logic [IW-1:0] mask_idx(input int ch);
    return (ch == 0) ? rxd_pkg::IDX_MASK_A : rxd_pkg::IDX_MASK_B;
  endfunction

  function automatic logic is_mapped(input logic [IW-1:0] a);
    return (a == rxd_pkg::IDX_CONTROL) || (a == rxd_pkg::IDX_SERDES_CTL) ||
           ((a >= rxd_pkg::IDX_IRQ_ENABLE) && (a <= rxd_pkg::IDX_MASK_B));
  endfunction

  // Bus side: one wait state, effects land at the edge that sees pready.
  assign access = psel & penable;
  assign done = access & pready_reg;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign idx = paddr[7:2];

  // Receive mode needs receive on and transmit off.
  assign rx_mode = control_reg[rxd_pkg::CTL_RX_EN] &
                   ~control_reg[rxd_pkg::CTL_TX_EN];
  assign stat_view = rx_mode ? flags : '0;

  always_comb begin
    rd_byte = '0;
    case (idx)
      rxd_pkg::IDX_CONTROL: rd_byte = control_reg;
      rxd_pkg::IDX_SERDES_CTL: rd_byte = serdes_reg;
      rxd_pkg::IDX_IRQ_ENABLE: rd_byte = irq_en_reg;
      rxd_pkg::IDX_IRQ_FLAGS: rd_byte = stat_view;
      rxd_pkg::IDX_BYTE_A: rd_byte = data_reg[0];
      rxd_pkg::IDX_MASK_A: rd_byte = mask_reg[0];
      rxd_pkg::IDX_BYTE_B: rd_byte = data_reg[1];
      rxd_pkg::IDX_MASK_B: rd_byte = mask_reg[1];
      default: rd_byte = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access & ~pready_reg;
    end
  end

  // Read data is captured one edge ahead and held through the answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (access && !pready_reg) begin
      prdata_reg <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
      pslverr_reg <= ~is_mapped(idx);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= rxd_pkg::CONTROL_RST;
    end else if (wr && idx == rxd_pkg::IDX_CONTROL) begin
      control_reg <= pwdata[BW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serdes_reg <= rxd_pkg::SERDES_RST;
    end else if (wr && idx == rxd_pkg::IDX_SERDES_CTL) begin
      serdes_reg <= pwdata[BW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= rxd_pkg::IRQ_EN_RST;
    end else if (wr && idx == rxd_pkg::IDX_IRQ_ENABLE) begin
      irq_en_reg <= pwdata[BW-1:0];
    end
  end

  assign chan_in[0] = rx_chan_a;
  assign chan_in[1] = rx_chan_b;

  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      localparam int B = ch * rxd_pkg::CH_STRIDE;
      logic rd_data;

      assign rd_data = rd && (idx == byte_idx(ch));

      rxd_chan u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .enable(rx_mode),
        .eof_len(serdes_reg[rxd_pkg::EOF_LEN_W-1:0]),
        .bits(chan_in[ch]),
        .ev(ev[ch])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          data_reg[ch] <= '0;
          mask_reg[ch] <= '0;
        end else if (ev[ch].load) begin
          data_reg[ch] <= ev[ch].data;
          mask_reg[ch] <= ev[ch].mask;
        end
      end

      // A fresh load wins over the host's read in the same cycle.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          unread_reg[ch] <= 1'b0;
        end else if (ev[ch].load) begin
          unread_reg[ch] <= 1'b1;
        end else if (rd_data) begin
          unread_reg[ch] <= 1'b0;
        end
      end

      assign flag_set[B + rxd_pkg::ST_FULL] = ev[ch].load;
      assign flag_set[B + rxd_pkg::ST_EOF] = ev[ch].eof;
      assign flag_set[B + rxd_pkg::ST_FLOW] =
        (ev[ch].load & unread_reg[ch]) |
        (rd_data & ~unread_reg[ch] & ~ev[ch].load);
      assign flag_set[B + rxd_pkg::ST_VALID] =
        ev[ch].load & (ev[ch].mask == rxd_pkg::ALL_VALID);
    end
  endgenerate

  // A status read clears only the bits it reported, so a flag raised
  // between capture and answer is kept for the next read.
  assign flag_clr = {BW{~rx_mode}} |
    ({BW{rd && idx == rxd_pkg::IDX_IRQ_FLAGS}} & prdata_reg[BW-1:0]) |
    ({BW{wr && idx == rxd_pkg::IDX_IRQ_FLAGS}} & pwdata[BW-1:0]);

  generate
    for (genvar f = 0; f < BW; f++) begin : g_flag
      rxd_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set(flag_set[f] & rx_mode),
        .clr(flag_clr[f]),
        .q(flags[f])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_view & irq_en_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
      (access && !pready_reg) |=> pready_reg ##1 !pready_reg;
  endproperty
  a_answer: assert property (p_answer)
    else $error("answer not after one wait state");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      (rx_mode && |(flags & irq_en_reg)) |=> irq_reg;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("enabled flag did not raise the interrupt");

  property p_stat_zero;
    @(posedge pclk) disable iff (!presetn)
      (rd && idx == rxd_pkg::IDX_IRQ_FLAGS && !rx_mode &&
       !$past(rx_mode)) |-> prdata_reg == 32'h00000000;
  endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("status not zero outside receive mode");

  property p_mask_ro;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == mask_idx(0) && !ev[0].load)
      |=> mask_reg[0] == $past(mask_reg[0]);
  endproperty
  a_mask_ro: assert property (p_mask_ro)
    else $error("mask register took a write");

  property p_all_valid;
    @(posedge pclk) disable iff (!presetn)
      $rose(flags[rxd_pkg::ST_VALID])
      |-> $past(ev[0].mask) == rxd_pkg::ALL_VALID;
  endproperty
  a_all_valid: assert property (p_all_valid)
    else $error("all-valid set on a partial byte");

  property p_overflow;
    @(posedge pclk) disable iff (!presetn)
      (rx_mode && ev[1].load && unread_reg[1])
      |=> flags[rxd_pkg::CH_STRIDE + rxd_pkg::ST_FLOW];
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not flagged");

  property p_full;
    @(posedge pclk) disable iff (!presetn)
      (rx_mode && ev[0].load) |=> flags[rxd_pkg::ST_FULL] &&
      data_reg[0] == $past(ev[0].data);
  endproperty
  a_full: assert property (p_full)
    else $error("byte move without full flag");

  property p_underflow;
    @(posedge pclk) disable iff (!presetn)
      (rx_mode && rd && idx == rxd_pkg::IDX_BYTE_A && !unread_reg[0] &&
       !ev[0].load) |=> flags[rxd_pkg::ST_FLOW];
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow not flagged");

  property p_underflow_b;
    @(posedge pclk) disable iff (!presetn)
      (rx_mode && rd && idx == byte_idx(1) && !unread_reg[1] &&
       !ev[1].load) |=> flags[rxd_pkg::CH_STRIDE + rxd_pkg::ST_FLOW];
  endproperty
  a_underflow_b: assert property (p_underflow_b)
    else $error("underflow not flagged on channel b");

  property p_overflow_a;
    @(posedge pclk) disable iff (!presetn)
      (rx_mode && ev[0].load && unread_reg[0])
      |=> flags[rxd_pkg::ST_FLOW];
  endproperty
  a_overflow_a: assert property (p_overflow_a)
    else $error("overflow not flagged on channel a");

  property p_full_b;
    @(posedge pclk) disable iff (!presetn)
      (rx_mode && ev[1].load)
      |=> flags[rxd_pkg::CH_STRIDE + rxd_pkg::ST_FULL] &&
      data_reg[1] == $past(ev[1].data);
  endproperty
  a_full_b: assert property (p_full_b)
    else $error("byte move without full flag on channel b");

  property p_all_valid_b;
    @(posedge pclk) disable iff (!presetn)
      $rose(flags[rxd_pkg::CH_STRIDE + rxd_pkg::ST_VALID])
      |-> $past(ev[1].mask) == rxd_pkg::ALL_VALID;
  endproperty
  a_all_valid_b: assert property (p_all_valid_b)
    else $error("all-valid set on a partial byte on channel b");

  property p_eof_flag;
    @(posedge pclk) disable iff (!presetn)
      (rx_mode && ev[0].eof) |=> flags[rxd_pkg::ST_EOF];
  endproperty
  a_eof_flag: assert property (p_eof_flag)
    else $error("frame end not flagged");

  // Bits reported by a status read must be gone unless set again.
  property p_stat_clear;
    @(posedge pclk) disable iff (!presetn)
      (rd && idx == rxd_pkg::IDX_IRQ_FLAGS && !(|flag_set))
      |=> ({24'h000000, flags} & $past(prdata_reg)) == 32'h00000000;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status read left a reported flag set");

  property p_mode_clear;
    @(posedge pclk) disable iff (!presetn)
      !rx_mode |=> flags == '0;
  endproperty
  a_mode_clear: assert property (p_mode_clear)
    else $error("flags kept outside receive mode");

  property p_irq_off;
    @(posedge pclk) disable iff (!presetn)
      !(rx_mode && |(flags & irq_en_reg)) |=> !irq_reg;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt without an enabled flag");

  property p_data_ro;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == byte_idx(0) && !ev[0].load)
      |=> data_reg[0] == $past(data_reg[0]);
  endproperty
  a_data_ro: assert property (p_data_ro)
    else $error("data register took a write");

  c_frame_a: cover property (@(posedge pclk) disable iff (!presetn)
    ev[0].load ##[1:200] ev[0].eof);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_reg));
  c_stat_read: cover property (@(posedge pclk) disable iff (!presetn)
    rd && idx == rxd_pkg::IDX_IRQ_FLAGS && prdata_reg != 32'h00000000);
  c_underflow: cover property (@(posedge pclk) disable iff (!presetn)
    rx_mode && rd && idx == byte_idx(0) && !unread_reg[0]);
  c_mode_drop: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(rx_mode) && |flags);
endmodule

/* shared/rxd_pkg.sv */
// Register map, field layout and carrier types of the receive deserializer.
// Assumes a 32-bit APB master on pclk and a radio front end on pclk.
package rxd_pkg;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 6;
  localparam int EOF_LEN_W = 3;
  // Byte address of a register is four times its index.
  localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h03;
  localparam logic [IDX_W-1:0] IDX_SERDES_CTL = 6'h06;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h07;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 6'h08;
  localparam logic [IDX_W-1:0] IDX_BYTE_A = 6'h09;
  localparam logic [IDX_W-1:0] IDX_MASK_A = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_BYTE_B = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_MASK_B = 6'h0c;
  localparam logic [BYTE_W-1:0] CONTROL_RST = 8'h00;
  localparam logic [BYTE_W-1:0] SERDES_RST = 8'h03;
  localparam logic [BYTE_W-1:0] IRQ_EN_RST = 8'h00;
  localparam logic [BYTE_W-1:0] ALL_VALID = 8'hff;
  localparam int CTL_RX_EN = 7;
  localparam int CTL_TX_EN = 6;
  localparam int ST_FULL = 0;
  localparam int ST_EOF = 1;
  localparam int ST_FLOW = 2;
  localparam int ST_VALID = 3;
  localparam int CH_STRIDE = 4;

  typedef enum logic [1:0] {
    RXD_IDLE = 2'b01,
    RXD_FRAME = 2'b10
  } rxd_chan_state_t;

  // One bit time from the correlator: tick marks the bit time.
  typedef struct packed {
    logic tick;
    logic valid;
    logic data;
  } rxd_bits_t;

  // A byte moving into a channel's data register.
  typedef struct packed {
    logic load;
    logic eof;
    logic [BYTE_W-1:0] data;
    logic [BYTE_W-1:0] mask;
  } rxd_load_t;
endpackage

/* rtl/rxd_flag.sv */
// One sticky status flag with set-over-clear priority.
// Assumes set and clear come from logic on pclk.
module rxd_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  logic q_reg;

  // A set in the cycle of a clear survives, so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= 1'b0;
    end else if (set) begin
      q_reg <= 1'b1;
    end else if (clr) begin
      q_reg <= 1'b0;
    end
  end

  assign q = q_reg;

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn) set |=> q_reg;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag lost a set");
endmodule

/* rtl/rxd_chan.sv */
// Deserializer for one receive channel: packs bits and detects frame end.
// Assumes one tick per bit time on pclk; enable is the receive mode.
module rxd_chan (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [rxd_pkg::EOF_LEN_W-1:0] eof_len,
  input wire rxd_pkg::rxd_bits_t bits,
  output rxd_pkg::rxd_load_t ev
);
  localparam int BW = rxd_pkg::BYTE_W;
  localparam int POS_W = $clog2(BW);
  localparam logic [POS_W-1:0] POS_LAST = POS_W'(BW - 1);

  rxd_pkg::rxd_chan_state_t st_reg;
  rxd_pkg::rxd_load_t ev_reg;
  logic [POS_W-1:0] pos_reg;
  logic [BW-1:0] shift_reg, mask_reg, shift_next, mask_next;
  logic [rxd_pkg::EOF_LEN_W:0] idle_reg;
  logic in_frame, slot, eof_hit, byte_done, flush;

  assign in_frame = st_reg == rxd_pkg::RXD_FRAME;
  // The run count before this bit reaching the length means it now exceeds.
  assign eof_hit = enable & bits.tick & in_frame & ~bits.valid &
                   (idle_reg >= {1'b0, eof_len});
  assign slot = enable & bits.tick & (in_frame | bits.valid) & ~eof_hit;
  assign byte_done = slot & (pos_reg == POS_LAST);
  assign flush = byte_done | (eof_hit & (|mask_reg));

  always_comb begin
    shift_next = shift_reg;
    mask_next = mask_reg;
    if (slot) begin
      shift_next[pos_reg] = bits.data;
      mask_next[pos_reg] = bits.valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= rxd_pkg::RXD_IDLE;
    end else if (!enable) begin
      st_reg <= rxd_pkg::RXD_IDLE;
    end else if (bits.tick) begin
      case (st_reg)
        rxd_pkg::RXD_IDLE: begin
          if (bits.valid) begin
            st_reg <= rxd_pkg::RXD_FRAME;
          end
        end
        rxd_pkg::RXD_FRAME: begin
          if (eof_hit) begin
            st_reg <= rxd_pkg::RXD_IDLE;
          end
        end
        default: begin
          st_reg <= rxd_pkg::RXD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= '0;
      shift_reg <= '0;
      mask_reg <= '0;
    end else if (!enable || flush || eof_hit) begin
      pos_reg <= '0;
      shift_reg <= '0;
      mask_reg <= '0;
    end else if (slot) begin
      pos_reg <= pos_reg + 1'b1;
      shift_reg <= shift_next;
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_reg <= '0;
    end else if (!enable || !in_frame || (slot && bits.valid)) begin
      idle_reg <= '0;
    end else if (slot && !(&idle_reg)) begin
      idle_reg <= idle_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_reg <= '0;
    end else begin
      ev_reg.load <= flush;
      ev_reg.eof <= eof_hit;
      ev_reg.data <= shift_next;
      ev_reg.mask <= mask_next;
    end
  end

  assign ev = ev_reg;

  property p_first_bit;
    @(posedge pclk) disable iff (!presetn)
      (enable && bits.tick && bits.valid && !in_frame)
      |=> (shift_reg[0] == $past(bits.data)) && mask_reg[0];
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first bit not in bit 0");

  property p_eof_len0;
    @(posedge pclk) disable iff (!presetn)
      (enable && bits.tick && in_frame && !bits.valid && eof_len == '0)
      |=> ev_reg.eof;
  endproperty
  a_eof_len0: assert property (p_eof_len0)
    else $error("length zero missed first invalid bit");

  property p_eof_cause;
    @(posedge pclk) disable iff (!presetn)
      ev_reg.eof |-> $past(in_frame) && !$past(bits.valid);
  endproperty
  a_eof_cause: assert property (p_eof_cause)
    else $error("frame end without an invalid bit in frame");
endmodule

/* rtl/_unused_placeholder_none.sv */
// Intentionally holds no logic; the design is complete in the files above.

/* test/rxd_radio_model.sv */
// Behavioural radio front end that feeds one receive channel bit by bit.
// Assumes the bench calls its task just after a rising edge of pclk.
module rxd_radio_model (
  input wire logic pclk,
  output rxd_pkg::rxd_bits_t bits
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bits = '0;
  end

  // Sends n back-to-back bit times, bit i carrying v[i] and d[i].
  // Between frames the qualifiers show the inverse of the last bit, so a
  // design that looks at them without the tick is caught out.
  task automatic frame(input int n, input logic [31:0] v,
                       input logic [31:0] d);
    logic lv;
    logic ld;
    lv = 1'b0;
    ld = 1'b0;
    for (int i = 0; i < n; i++) begin
      bits <= '{tick: 1'b1, valid: v[i], data: d[i]};
      lv = v[i];
      ld = d[i];
      @(posedge pclk);
    end
    bits <= '{tick: 1'b0, valid: ~lv, data: ~ld};
    @(posedge pclk);
  endtask
endmodule

/* test/test_dual_channel_rx_deserializer_flags.sv */
// Self-checking bench for the receive deserializer register block.
// Assumes the APB answer carries one wait state and flags settle within
// three edges of the last tick.
module test_dual_channel_rx_deserializer_flags;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  rxd_pkg::rxd_bits_t rx_a;
  rxd_pkg::rxd_bits_t rx_b;
  int n_errors = 0;
  int checks = 0;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'h0000_3f1c;
  logic [7:0] r1;
  logic [7:0] r2;

  always #2.5 pclk = ~pclk;

  rxd_top u_rxd_top (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_chan_a(rx_a),
    .rx_chan_b(rx_b),
    .irq(irq)
  );

  rxd_radio_model u_radio_a (.pclk(pclk), .bits(rx_a));
  rxd_radio_model u_radio_b (.pclk(pclk), .bits(rx_b));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic next_rand(output logic [7:0] r);
    repeat (8) seed = lfsr(seed);
    r = seed[7:0];
  endtask

  task automatic fail(input string msg);
    n_errors++;
    $display("CHECK FAILED %0t %s", $time, msg);
  endtask

  task automatic cmp_rd(input logic [32:0] e);
    checks++;
    if ({pslverr, prdata} !== e) fail("bus answer differs");
  endtask

  task automatic cmp_irq(input logic e);
    checks++;
    if (irq !== e) fail("interrupt level differs");
  endtask

  // The note is queued before the request, so the watcher finds it at
  // the answering edge whichever process runs first.
  task automatic apb(input logic w, input logic [5:0] idx,
                     input logic [7:0] wd, input logic [7:0] ed,
                     input logic ee);
    exp_q.push_back({ee, 24'h00_0000, ed});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, e, 1'b0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic end_sim;
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("answer with nothing expected");
      end else begin
        cmp_rd(exp_q.pop_front());
      end
    end
  end

  initial begin
    idle(20000);
    fail("watchdog ran out");
    end_sim();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(rxd_pkg::IDX_BYTE_A, 8'h55);
    for (int i = 7; i <= 12; i++) begin
      rd(6'(i), 8'h00);
    end
    rd(rxd_pkg::IDX_SERDES_CTL, rxd_pkg::SERDES_RST);
    apb(1'b0, 6'h3f, 8'h00, 8'h00, 1'b1);
    wr(rxd_pkg::IDX_IRQ_ENABLE, 8'ha5);
    rd(rxd_pkg::IDX_IRQ_ENABLE, 8'ha5);
    wr(rxd_pkg::IDX_IRQ_ENABLE, 8'h00);
    wr(rxd_pkg::IDX_CONTROL, 8'h80);
    // A full byte, then one invalid bit more than the length of three.
    next_rand(r1);
    u_radio_a.frame(12, 32'h0000_00ff, {24'h00_0000, r1});
    idle(3);
    cmp_irq(1'b0);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h0b);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h00);
    rd(rxd_pkg::IDX_BYTE_A, r1);
    wr(rxd_pkg::IDX_MASK_A, 8'h00);
    rd(rxd_pkg::IDX_MASK_A, rxd_pkg::ALL_VALID);
    rd(rxd_pkg::IDX_BYTE_A, r1);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h04);
    // Two bytes unread on B, then exactly the length in invalid bits.
    next_rand(r1);
    next_rand(r2);
    wr(rxd_pkg::IDX_IRQ_ENABLE, 8'h40);
    u_radio_b.frame(19, 32'h0000_ffff, {16'h0000, r2, r1});
    idle(3);
    cmp_irq(1'b1);
    wr(rxd_pkg::IDX_IRQ_ENABLE, 8'h00);
    idle(1);
    cmp_irq(1'b0);
    wr(rxd_pkg::IDX_IRQ_ENABLE, 8'h40);
    idle(1);
    cmp_irq(1'b1);
    wr(rxd_pkg::IDX_IRQ_FLAGS, 8'h40);
    idle(1);
    cmp_irq(1'b0);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h90);
    rd(rxd_pkg::IDX_BYTE_B, r2);
    rd(rxd_pkg::IDX_MASK_B, rxd_pkg::ALL_VALID);
    rd(rxd_pkg::IDX_BYTE_B, r2);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h40);
    // Length zero: one valid bit, then the first invalid bit ends it.
    wr(rxd_pkg::IDX_SERDES_CTL, 8'h00);
    u_radio_a.frame(2, 32'h0000_0001, {31'h0000_0000, r1[0]});
    idle(3);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h03);
    rd(rxd_pkg::IDX_MASK_A, 8'h01);
    // Status vanishes once transmit mode joins receive mode.
    wr(rxd_pkg::IDX_IRQ_ENABLE, 8'hff);
    u_radio_a.frame(8, 32'h0000_00ff, {24'h00_0000, r2});
    idle(3);
    cmp_irq(1'b1);
    wr(rxd_pkg::IDX_CONTROL, 8'hc0);
    idle(1);
    cmp_irq(1'b0);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h00);
    u_radio_a.frame(8, 32'h0000_00ff, {24'h00_0000, ~r2});
    idle(3);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h00);
    wr(rxd_pkg::IDX_CONTROL, 8'h80);
    rd(rxd_pkg::IDX_IRQ_FLAGS, 8'h00);
    rd(rxd_pkg::IDX_BYTE_A, r2);
    idle(2);
    end_sim();
  end
endmodule
